/* common/stdtm_pkg.sv */
package stdtm_pkg;
    // register byte offsets
    localparam logic [7:0] STDTM_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] STDTM_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] STDTM_OFF_CNT = 8'h08;
    localparam logic [7:0] STDTM_OFF_CMPA = 8'h0C;
    localparam logic [7:0] STDTM_OFF_CMPP = 8'h10;
    localparam logic [7:0] STDTM_OFF_FLAGS = 8'h14;
    // ctrl0 fields
    localparam int STDTM_C0_ENABLE = 0;
    localparam int STDTM_C0_CKSEL = 1;
    localparam int STDTM_C0_TRIG_FALL = 2;
    // ctrl1 (timer_ctrl1) fields
    localparam int STDTM_C1_CCLR = 0;
    localparam int STDTM_C1_DPX = 1;
    localparam int STDTM_C1_POL = 2;
    localparam int STDTM_C1_OC = 3;
    localparam int STDTM_C1_IO_LO = 4;
    localparam int STDTM_C1_MODE_LO = 6;
    // flag fields
    localparam int STDTM_FL_A = 0;
    localparam int STDTM_FL_P = 1;
    // reset value and bus response codes
    localparam logic [31:0] STDTM_RST_WORD = 32'h0000_0000;
    localparam logic [1:0] STDTM_RESP_OKAY = 2'h0;
    localparam logic [1:0] STDTM_RESP_SLVERR = 2'h2;
    // modes, pin functions and counter maximum
    localparam logic [1:0] STDTM_MODE_CMP = 2'h0;
    localparam logic [1:0] STDTM_MODE_PWM = 2'h2;
    localparam logic [1:0] STDTM_MODE_TMR = 2'h3;
    localparam logic [1:0] STDTM_IO_NONE = 2'h0;
    localparam logic [1:0] STDTM_IO_LOW = 2'h1;
    localparam logic [1:0] STDTM_IO_HIGH = 2'h2;
    localparam logic [1:0] STDTM_IO_TOG = 2'h3;
    localparam logic [1:0] STDTM_IO_INACT = 2'h0;
    localparam logic [1:0] STDTM_IO_ACT = 2'h1;
    localparam logic [1:0] STDTM_IO_PWM = 2'h2;
    localparam logic [1:0] STDTM_IO_PULSE = 2'h3;
    localparam logic [15:0] STDTM_CNT_MAX = 16'hFFFF;
endpackage

/* design/stdtm_edge.sv */
`timescale 1ns/1ps
// one-cycle pulse on a selected edge of a synchronous input
module stdtm_edge (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    // signal
    input wire logic sig_in,
    input wire logic fall_in,
    output logic edge_out
);
    logic prev;
    wire rise_w = sig_in & ~prev;
    wire fall_w = ~sig_in & prev;
    assign edge_out = fall_in ? fall_w : rise_w;
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            prev <= 1'b0;
        end else begin
            prev <= sig_in;
        end
    end
endmodule

/* design/stdtm_top.sv */
`timescale 1ns/1ps
// Behaviour
// - compare mode, compare A zero: no A flag; with clear select 1 the counter wraps at FFFF
// - compare mode: pin moves only on A match or enable rise; P match never moves it
// - A match drives pin high, low or toggles per pin function
// - enable rising edge loads pin with initial level from out control
// - compare or mode 11, clear select 0: P match clears counter; both A and P flags raise
// - compare or mode 11, clear select 1: A match clears counter; P flag never raised
// - mode 11 counts and flags like compare mode, pin unused
// - PWM ignores clear select; period register chosen by swap bit
// - swap clear: P period, A duty; set: A period, P duty
// - P value in 256-clock units; zero means 65536 clocks
// - duty at or above period gives full-period active output
// - PWM raises separate A and P flags on each match
// - PWM: out control sets active level; pin function forces or enables
// - polarity bit inverts output pin
// - PWM counting continues while pin is forced to fixed level
// - single pulse: trigger pin edge sets enable bit unless pin is counting clock; beats A match and software write
// - enable high in single pulse starts counter, pulse leading edge
// - A match clears enable, ends pulse, raises flag; software clear ends too
// - single pulse zeroes counter only on enable rise; ignores P and bits
// - compare pin function: 00 none, 01 low, 10 high, 11 toggle
// - P compared with counter bits 15..8; zero lets counter overflow
module stdtm_top
    import stdtm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    // axi4-lite write address
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    // axi4-lite write data
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // timer pins
    input wire logic EXT_TRIGGER_PIN_IN,
    input wire logic CNT_TICK_IN,
    output logic TIMER_PIN_OUT
);
    // software-visible state, plus internal pin level and enable delay
    logic timer_enable_bit;
    logic ext_clk_sel;
    logic trig_fall;
    logic [7:0] timer_ctrl1;
    logic [CNT_W-1:0] compare_a_value;
    logic [7:0] compare_p_value;
    logic [CNT_W-1:0] count;
    logic cmp_a_flag;
    logic cmp_p_flag;
    logic pin_lvl;
    logic en_prev;

    // control fields
    wire [1:0] mode_sel = timer_ctrl1[STDTM_C1_MODE_LO +: 2];
    wire [1:0] pin_func = timer_ctrl1[STDTM_C1_IO_LO +: 2];
    wire out_ctrl_bit = timer_ctrl1[STDTM_C1_OC];
    wire out_invert_bit = timer_ctrl1[STDTM_C1_POL];
    wire duty_period_swap = timer_ctrl1[STDTM_C1_DPX];
    wire clear_select_bit = timer_ctrl1[STDTM_C1_CCLR];
    wire is_pwm = (mode_sel == STDTM_MODE_PWM) && (pin_func != STDTM_IO_PULSE);
    wire is_pulse = (mode_sel == STDTM_MODE_PWM) && (pin_func == STDTM_IO_PULSE);
    wire is_cmp = (mode_sel == STDTM_MODE_CMP) || (mode_sel == STDTM_MODE_TMR);

    // counting clock: ext trigger pin edge or internal tick
    logic ext_edge;
    stdtm_edge u_edge (
        .MCLK_IN(MCLK_IN),
        .NRST_IN(NRST_IN),
        .sig_in(EXT_TRIGGER_PIN_IN),
        .fall_in(trig_fall),
        .edge_out(ext_edge)
    );
    wire tick = ext_clk_sel ? ext_edge : CNT_TICK_IN;
    wire step = timer_enable_bit & tick;

    // comparators; P only sees the high byte
    wire [CNT_W-1:0] cnt_inc = count + 1'b1;
    wire p_zero = (compare_p_value == 8'h00);
    wire a_zero = (compare_a_value == '0);
    wire cnt_wrap = (count == STDTM_CNT_MAX[CNT_W-1:0]);
    // P match: high byte of next count hits P, or overflow when P zero
    wire p_hit = p_zero ? cnt_wrap : (cnt_inc[CNT_W-1 -: 8] == compare_p_value) && (cnt_inc[CNT_W-9:0] == '0);
    wire a_hit = !a_zero && (cnt_inc == compare_a_value);
    wire a_hit_pwm = a_zero ? cnt_wrap : (cnt_inc == compare_a_value);

    // per-mode clear and flag decisions
    wire cmp_clr = clear_select_bit ? a_hit : p_hit;
    wire cmp_set_p = !clear_select_bit && p_hit;
    wire pwm_clr = duty_period_swap ? a_hit_pwm : p_hit;
    wire next_clear = is_cmp ? cmp_clr : (is_pwm ? pwm_clr : 1'b0);
    wire set_a = step && (is_pwm ? a_hit_pwm : a_hit);
    wire set_p = step && !is_pulse && (is_cmp ? cmp_set_p : p_hit);
    wire [CNT_W-1:0] next_count = next_clear ? '0 : cnt_inc;

    // pwm duty compare, extended so P zero means 65536
    wire [CNT_W:0] p_span = p_zero ? {1'b1, {CNT_W{1'b0}}} : {1'b0, compare_p_value, 8'h00};
    wire [CNT_W:0] a_span = {1'b0, compare_a_value};
    wire [CNT_W:0] period = duty_period_swap ? a_span : p_span;
    wire [CNT_W:0] duty = duty_period_swap ? p_span : a_span;
    wire pwm_act = (duty >= period) || ({1'b0, count} < duty);
    wire pwm_raw = (pin_func == STDTM_IO_ACT) ? 1'b1 : ((pin_func == STDTM_IO_INACT) ? 1'b0 : pwm_act);
    wire pwm_lvl = out_ctrl_bit ? pwm_raw : ~pwm_raw;

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == STDTM_OFF_CTRL0) || (a == STDTM_OFF_CTRL1) || (a == STDTM_OFF_CNT) ||
            (a == STDTM_OFF_CMPA) || (a == STDTM_OFF_CMPP) || (a == STDTM_OFF_FLAGS);
    endfunction

    // bus decode
    wire aw_take = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT;
    wire ar_take = S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT;
    wire [7:0] waddr = S_AXI_AWADDR_IN;
    wire wr_c0 = aw_take && (waddr == STDTM_OFF_CTRL0) && S_AXI_WSTRB_IN[0];
    wire wr_c1 = aw_take && (waddr == STDTM_OFF_CTRL1) && S_AXI_WSTRB_IN[0];
    wire wr_a = aw_take && (waddr == STDTM_OFF_CMPA);
    wire wr_p = aw_take && (waddr == STDTM_OFF_CMPP) && S_AXI_WSTRB_IN[0];
    wire wr_fl = aw_take && (waddr == STDTM_OFF_FLAGS) && S_AXI_WSTRB_IN[0];
    wire w_map = reg_mapped(waddr);
    // a write stands for two edges; only the first one lands
    wire wr_once = !S_AXI_AWREADY_OUT;

    // enable: software, trigger edge in single pulse, A match ends pulse
    // trigger and pulse end still act in the write's second cycle
    wire sw_en = (wr_c0 && wr_once) ? S_AXI_WDATA_IN[STDTM_C0_ENABLE] : timer_enable_bit;
    wire trig_set = is_pulse && !ext_clk_sel && ext_edge;
    wire pulse_end = is_pulse && step && a_hit;
    wire next_enable = trig_set ? 1'b1 : (pulse_end ? 1'b0 : sw_en);
    wire en_rise = timer_enable_bit && !en_prev;

    function automatic logic cmp_pin(input logic cur, input logic [1:0] fn);
        cmp_pin = (fn == STDTM_IO_LOW) ? 1'b0 : (fn == STDTM_IO_HIGH) ? 1'b1 : (fn == STDTM_IO_TOG) ? ~cur : cur;
    endfunction

    // pin level before polarity
    wire pulse_lvl = timer_enable_bit ? out_ctrl_bit : ~out_ctrl_bit;
    wire next_pin = en_rise ? out_ctrl_bit :
        (mode_sel == STDTM_MODE_CMP) ? ((set_a) ? cmp_pin(pin_lvl, pin_func) : pin_lvl) :
        (mode_sel == STDTM_MODE_TMR) ? pin_lvl :
        is_pwm ? pwm_lvl : pulse_lvl;

    // read mux
    wire [31:0] rd_word = (S_AXI_ARADDR_IN == STDTM_OFF_CTRL0) ? {29'h0, trig_fall, ext_clk_sel, timer_enable_bit} :
        (S_AXI_ARADDR_IN == STDTM_OFF_CTRL1) ? {24'h0, timer_ctrl1} :
        (S_AXI_ARADDR_IN == STDTM_OFF_CNT) ? {{(32-CNT_W){1'b0}}, count} :
        (S_AXI_ARADDR_IN == STDTM_OFF_CMPA) ? {{(32-CNT_W){1'b0}}, compare_a_value} :
        (S_AXI_ARADDR_IN == STDTM_OFF_CMPP) ? {24'h0, compare_p_value} :
        (S_AXI_ARADDR_IN == STDTM_OFF_FLAGS) ? {30'h0, cmp_p_flag, cmp_a_flag} : 32'h0;
    wire r_map = reg_mapped(S_AXI_ARADDR_IN);

    // axi write channel
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            S_AXI_AWREADY_OUT <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= STDTM_RESP_OKAY;
        end else begin
            S_AXI_AWREADY_OUT <= aw_take && !S_AXI_AWREADY_OUT;
            S_AXI_WREADY_OUT <= aw_take && !S_AXI_WREADY_OUT;
            if (S_AXI_AWREADY_OUT) begin
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= w_map ? STDTM_RESP_OKAY : STDTM_RESP_SLVERR;
            end else if (S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= STDTM_RST_WORD;
            S_AXI_RRESP_OUT <= STDTM_RESP_OKAY;
        end else begin
            S_AXI_ARREADY_OUT <= ar_take && !S_AXI_ARREADY_OUT;
            if (ar_take && !S_AXI_ARREADY_OUT) begin
                S_AXI_RVALID_OUT <= 1'b1;
                S_AXI_RDATA_OUT <= rd_word;
                S_AXI_RRESP_OUT <= r_map ? STDTM_RESP_OKAY : STDTM_RESP_SLVERR;
            end else if (S_AXI_RREADY_IN) begin
                S_AXI_RVALID_OUT <= 1'b0;
            end
        end
    end

    // configuration registers; write taken only once per handshake
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ext_clk_sel <= 1'b0;
            trig_fall <= 1'b0;
            timer_ctrl1 <= STDTM_RST_WORD[7:0];
            compare_a_value <= '0;
            compare_p_value <= STDTM_RST_WORD[7:0];
        end else if (wr_once) begin
            if (wr_c0) begin
                ext_clk_sel <= S_AXI_WDATA_IN[STDTM_C0_CKSEL];
                trig_fall <= S_AXI_WDATA_IN[STDTM_C0_TRIG_FALL];
            end
            if (wr_c1) begin
                timer_ctrl1 <= S_AXI_WDATA_IN[7:0];
            end
            if (wr_a) begin
                compare_a_value <= S_AXI_WDATA_IN[CNT_W-1:0];
            end
            if (wr_p) begin
                compare_p_value <= S_AXI_WDATA_IN[7:0];
            end
        end
    end

    // counter, enable, pin
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            timer_enable_bit <= 1'b0;
            en_prev <= 1'b0;
            count <= '0;
            pin_lvl <= 1'b0;
        end else begin
            timer_enable_bit <= next_enable;
            en_prev <= timer_enable_bit;
            if (timer_enable_bit && !en_prev) begin
                count <= '0;
            end else if (step) begin
                count <= next_count;
            end
            pin_lvl <= next_pin;
        end
    end

    // output through polarity, from a flop
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            TIMER_PIN_OUT <= 1'b0;
        end else begin
            TIMER_PIN_OUT <= (mode_sel == STDTM_MODE_TMR) ? 1'b0 : (next_pin ^ out_invert_bit);
        end
    end

    // sticky flags: hardware set beats software clear (write 1 clears)
    wire clr_a = wr_fl && wr_once && S_AXI_WDATA_IN[STDTM_FL_A];
    wire clr_p = wr_fl && wr_once && S_AXI_WDATA_IN[STDTM_FL_P];
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cmp_a_flag <= 1'b0;
            cmp_p_flag <= 1'b0;
        end else begin
            cmp_a_flag <= set_a | (cmp_a_flag & ~clr_a);
            cmp_p_flag <= set_p | (cmp_p_flag & ~clr_p);
        end
    end

    // assertions
    a_flag_a_sticky: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        set_a |=> cmp_a_flag) else $error("A flag not set after match");
    a_no_p_cclr: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_cmp && clear_select_bit) |-> !set_p) else $error("P flag raised with A clear");
    a_wrap_no_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_cmp && a_zero && step) |-> !set_a) else $error("A flag with zero compare");
    a_enable_init: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (timer_enable_bit && !en_prev && mode_sel == STDTM_MODE_CMP) |=> pin_lvl == $past(out_ctrl_bit))
        else $error("pin not initialised on enable");
    a_pulse_end: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (pulse_end && !trig_set) |=> !timer_enable_bit) else $error("pulse did not stop enable");
    a_trig_sets: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        trig_set |=> timer_enable_bit) else $error("trigger did not set enable");
    a_cnt_restart: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (timer_enable_bit && !en_prev) |=> count == '0) else $error("counter not zeroed on start");
    a_p_only_pin: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (mode_sel == STDTM_MODE_CMP && !set_a && !en_rise) |=> $stable(pin_lvl))
        else $error("pin moved without A match");

    // compare and timer mode checks, then P byte and counter step checks for any mode
    wire cmp_act = (mode_sel == STDTM_MODE_CMP) && set_a && !en_rise;
    a_pin_toggle: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (cmp_act && pin_func == STDTM_IO_TOG) |=> pin_lvl != $past(pin_lvl))
        else $error("pin did not toggle");
    a_pin_low: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (cmp_act && pin_func == STDTM_IO_LOW) |=> !pin_lvl)
        else $error("pin not driven low");
    a_pin_high: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (cmp_act && pin_func == STDTM_IO_HIGH) |=> pin_lvl)
        else $error("pin not driven high");
    a_p_clear: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_cmp && !clear_select_bit && step && p_hit) |=> count == '0)
        else $error("P match did not clear");
    a_p_flag_raise: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_cmp && !clear_select_bit && step && p_hit) |=> cmp_p_flag)
        else $error("P flag missing");
    a_a_clear: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_cmp && clear_select_bit && step && a_hit) |=> count == '0)
        else $error("A match did not clear");
    a_tmr_pin: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (mode_sel == STDTM_MODE_TMR) |=> !TIMER_PIN_OUT)
        else $error("pin used in timer mode");
    a_p_high_byte: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (step && !p_zero && p_hit) |-> &count[CNT_W-9:0])
        else $error("P match off byte boundary");
    a_count_step: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (step && !next_clear && !en_rise) |=> count == $past(cnt_inc))
        else $error("counter did not step");

    // pwm, polarity and pulse checks
    a_pwm_period: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pwm && step && (duty_period_swap ? a_hit_pwm : p_hit)) |=> count == '0)
        else $error("period match did not clear");
    a_full_duty: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pwm && pin_func == STDTM_IO_PWM && duty >= period && !en_rise) |=> TIMER_PIN_OUT == $past(out_ctrl_bit ^ out_invert_bit))
        else $error("full duty not active");
    a_pwm_p_flag: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pwm && step && p_hit) |=> cmp_p_flag)
        else $error("pwm P flag missing");
    a_force_level: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pwm && pin_func == STDTM_IO_INACT && !en_rise) |=> TIMER_PIN_OUT == $past(~out_ctrl_bit ^ out_invert_bit))
        else $error("forced level wrong");
    a_out_polarity: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (mode_sel != STDTM_MODE_TMR) |=> TIMER_PIN_OUT == (pin_lvl ^ $past(out_invert_bit)))
        else $error("polarity not applied");
    a_forced_counts: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pwm && pin_func != STDTM_IO_PWM && step && !pwm_clr && !en_rise) |=> count == $past(cnt_inc))
        else $error("forced pwm stopped counting");
    a_pulse_lead: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pulse && timer_enable_bit) |=> pin_lvl == $past(out_ctrl_bit))
        else $error("pulse not active");
    a_pulse_trail: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (is_pulse && !timer_enable_bit) |=> pin_lvl != $past(out_ctrl_bit))
        else $error("pulse not ended");
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import stdtm_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic trig = 1'b0, tick_en = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    int error_cnt = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    stdtm_top #(.CNT_W(16)) stdtm_top_inst (.MCLK_IN(clk), .NRST_IN(nrst),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .EXT_TRIGGER_PIN_IN(trig), .CNT_TICK_IN(tick_en), .TIMER_PIN_OUT(pin));
    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 200) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: bus wait ran out", $time);
            results();
        end
    endtask
    // write address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
            guard(n);
        end
        do begin @(posedge clk); guard(n); end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ar_ok;
        n = 0;
        ar_ok = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) begin ar_ok = 1'b1; arvalid <= 1'b0; end
            guard(n);
        end while (!(ar_ok && rvalid === 1'b1));
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        check({30'h0, r}, {30'h0, STDTM_RESP_OKAY});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [1:0] r;
        rdw(a, rd, r);
        check(rd & mask, exp);
        check({30'h0, r}, {30'h0, STDTM_RESP_OKAY});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // counting events only while the bus is quiet, so counts stay exact
    task automatic tick(input int n);
        @(posedge clk);
        tick_en <= 1'b1;
        repeat (n - 1) @(posedge clk);
        @(posedge clk);
        tick_en <= 1'b0;
        idle(3);
    endtask
    // n high pulses on the trigger pin, each one rising and one falling edge
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge clk);
            trig <= 1'b1;
            idle(2);
            trig <= 1'b0;
            idle(2);
        end
    endtask
    task automatic pchk(input logic exp);
        idle(3);
        check({31'h0, pin}, {31'h0, exp});
    endtask
    function automatic logic [31:0] c1(input logic [1:0] m, input logic [1:0] io, input logic oc,
        input logic pol, input logic dpx, input logic cclr);
        return {24'h0, m, io, oc, pol, dpx, cclr};
    endfunction
    // timer is stopped before any mode change, as the pin logic demands
    task automatic setup(input logic [31:0] ctl, input logic [15:0] a, input logic [7:0] p, input logic en);
        w(STDTM_OFF_CTRL0, 32'h0);
        w(STDTM_OFF_FLAGS, 32'h3);
        w(STDTM_OFF_CMPA, {16'h0, a});
        w(STDTM_OFF_CMPP, {24'h0, p});
        w(STDTM_OFF_CTRL1, ctl);
        w(STDTM_OFF_CTRL0, {31'h0, en});
    endtask
    logic [1:0] resp;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic ocb, expb;
    logic [1:0] iob;
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        foreach (offs[i]) rchk(offs[i], 32'hFFFF_FFFF, STDTM_RST_WORD);
        rdw(8'h18, rd, resp);
        check({30'h0, resp}, {30'h0, STDTM_RESP_SLVERR});
        check(rd, 32'h0);
        wr(8'h18, 32'h1, resp);
        check({30'h0, resp}, {30'h0, STDTM_RESP_SLVERR});
        for (int i = 0; i < 8; i++) begin
            ocb = i[2];
            iob = i[1:0];
            expb = (iob == STDTM_IO_NONE) ? ocb : (iob == STDTM_IO_LOW) ? 1'b0 : (iob == STDTM_IO_HIGH) ? 1'b1 : ~ocb;
            setup(c1(STDTM_MODE_CMP, iob, ocb, 1'b0, 1'b0, 1'b1), 16'h5, 8'h0, 1'b1);
            pchk(ocb);
            tick(3);
            rchk(STDTM_OFF_CNT, 32'hFFFF, 32'h3);
            pchk(ocb);
            tick(2);
            rchk(STDTM_OFF_FLAGS, 32'h3, 32'h1);
            pchk(expb);
            rchk(STDTM_OFF_FLAGS, 32'h3, 32'h1);
            w(STDTM_OFF_FLAGS, 32'h3);
            rchk(STDTM_OFF_FLAGS, 32'h3, 32'h0);
        end
        setup(c1(STDTM_MODE_CMP, STDTM_IO_TOG, 1'b0, 1'b0, 1'b0, 1'b0), 16'h10, 8'h1, 1'b1);
        tick(16);
        rchk(STDTM_OFF_FLAGS, 32'h3, 32'h1);
        pchk(1'b1);
        w(STDTM_OFF_FLAGS, 32'h3);
        tick(240);
        rchk(STDTM_OFF_FLAGS, 32'h3, 32'h2);
        pchk(1'b1);
        tick(20);
        rchk(STDTM_OFF_FLAGS, 32'h3, 32'h3);
        pchk(1'b0);
        setup(c1(STDTM_MODE_TMR, STDTM_IO_HIGH, 1'b1, 1'b0, 1'b0, 1'b1), 16'h4, 8'h0, 1'b1);
        tick(4);
        rchk(STDTM_OFF_FLAGS, 32'h3, 32'h1);
        pchk(1'b0);
        for (int pol = 0; pol < 2; pol++) begin
            setup(c1(STDTM_MODE_PWM, STDTM_IO_PWM, 1'b1, pol[0], 1'b0, 1'b1), 16'h40, 8'h1, 1'b1);
            pchk(~pol[0]);
            tick(70);
            pchk(pol[0]);
            rchk(STDTM_OFF_FLAGS, 32'h3, 32'h1);
            tick(190);
            rchk(STDTM_OFF_FLAGS, 32'h3, 32'h3);
            pchk(~pol[0]);
            rdw(STDTM_OFF_CNT, rd, resp);
            check({31'h0, rd < 32'h10}, 32'h1);
        end
        for (int f = 0; f < 2; f++) begin
            setup(c1(STDTM_MODE_PWM, f[0] ? STDTM_IO_ACT : STDTM_IO_INACT, 1'b1, 1'b0, 1'b0, 1'b0), 16'h40, 8'h1, 1'b1);
            pchk(f[0]);
            tick(70);
            pchk(f[0]);
            rchk(STDTM_OFF_FLAGS, 32'h3, 32'h1);
            rchk(STDTM_OFF_CNT, 32'hFFFF, 32'h46);
        end
        setup(c1(STDTM_MODE_PWM, STDTM_IO_PWM, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0200, 8'h1, 1'b1);
        repeat (3) begin
            tick(100);
            pchk(1'b1);
        end
        setup(c1(STDTM_MODE_PWM, STDTM_IO_PWM, 1'b1, 1'b0, 1'b1, 1'b0), 16'h28, 8'h0, 1'b1);
        tick(45);
        pchk(1'b1);
        rchk(STDTM_OFF_FLAGS, 32'h1, 32'h1);
        rdw(STDTM_OFF_CNT, rd, resp);
        check({31'h0, rd < 32'h10}, 32'h1);
        setup(c1(STDTM_MODE_PWM, STDTM_IO_PULSE, 1'b1, 1'b0, 1'b1, 1'b0), 16'h1E, 8'h2, 1'b0);
        edges(1);
        idle(2);
        rchk(STDTM_OFF_CTRL0, 32'h1, 32'h1);
        pchk(1'b1);
        tick(10);
        rchk(STDTM_OFF_CNT, 32'hFFFF, 32'hA);
        tick(25);
        rchk(STDTM_OFF_CTRL0, 32'h1, 32'h0);
        pchk(1'b0);
        rchk(STDTM_OFF_FLAGS, 32'h1, 32'h1);
        w(STDTM_OFF_CTRL0, 32'h1);
        pchk(1'b1);
        rchk(STDTM_OFF_CNT, 32'hFFFF, 32'h0);
        w(STDTM_OFF_CTRL0, 32'h0);
        pchk(1'b0);
        // trigger pin as counting clock, rising edges then falling edges
        setup(c1(STDTM_MODE_CMP, STDTM_IO_NONE, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0100, 8'h0, 1'b0);
        w(STDTM_OFF_CTRL0, 32'h3);
        edges(4);
        rchk(STDTM_OFF_CNT, 32'hFFFF, 32'h4);
        w(STDTM_OFF_CTRL0, 32'h7);
        edges(2);
        rchk(STDTM_OFF_CNT, 32'hFFFF, 32'h6);
        // long run last: full 16-bit wrap needs every count value
        setup(c1(STDTM_MODE_CMP, STDTM_IO_TOG, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0, 8'h0, 1'b1);
        tick(65535);
        rchk(STDTM_OFF_CNT, 32'hFFFF, {16'h0, STDTM_CNT_MAX});
        tick(1);
        rchk(STDTM_OFF_CNT, 32'hFFFF, 32'h0);
        rchk(STDTM_OFF_FLAGS, 32'h3, 32'h0);
        pchk(1'b0);
        results();
    end
endmodule
